// ==== core/src_response_setup.v ====
`timescale 1ns/1ns
`include "src_consts.vh"
// stimulus-3 response setup register and its decode onto the data lines
module src_response_setup (
  // clock and reset
  input  wire       clk,
  input  wire       reset,
  // register port
  input  wire [7:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWrite,
  input  wire       regRead,
  output reg  [7:0] regRdata,
  // sequencer side
  input  wire [2:0] triggerSelectA,
  input  wire       stimDetected,
  input  wire       chargePortProfile,
  input  wire       emuReset,
  // response outputs, positive line
  output reg  [1:0] portDataPositiveKind,
  output wire       portDataPositivePullDown,
  // response outputs, negative line
  output reg  [1:0] portDataNegativeKind,
  output wire       portDataNegativePullDown,
  // shared response state
  output reg  [3:0] appliedLevel,
  output reg        linesShorted
);
  reg  [3:0] levelQ;
  reg  [3:0] selectQ;
  wire [3:0] wrLevel = regWdata[`SRC_LEVEL_MSB:`SRC_LEVEL_LSB];
  wire [3:0] wrSelect = regWdata[`SRC_SEL_MSB:`SRC_SEL_LSB];
  wire       wrHit = regWrite && (regAddr == `SRC_ADDR_SETUP);
  wire       selBad = (wrSelect == `SRC_SEL_BAD_A) || (wrSelect == `SRC_SEL_BAD_B)
                      || (wrSelect == `SRC_SEL_BAD_C);

  // reset byte split by field so each flop gets exactly its own width
  localparam [7:0] RESET_SETUP = `SRC_RESET_SETUP;

  // each field takes a write only if its code is legal
  always @(posedge clk) begin
    if (reset) begin
      levelQ  <= RESET_SETUP[`SRC_LEVEL_MSB:`SRC_LEVEL_LSB];
      selectQ <= RESET_SETUP[`SRC_SEL_MSB:`SRC_SEL_LSB];
    end else if (wrHit) begin
      if (wrLevel != `SRC_LEVEL_BAD)
        levelQ <= wrLevel;
      if (!selBad)
        selectQ <= wrSelect;
    end
  end

  // decode of select into kind and line targets
  reg [1:0] kind;
  reg       hitPos;
  reg       hitNeg;
  reg       pdCmd;
  always @* begin
    kind   = `SRC_KIND_NONE;
    hitPos = 1'b0;
    hitNeg = 1'b0;
    pdCmd  = 1'b0;
    case (selectQ)
      // voltage responses, level read as millivolts
      `SRC_SEL_V_POS: begin
        kind   = `SRC_KIND_VOLT;
        hitPos = 1'b1;
      end
      `SRC_SEL_V_NEG: begin
        kind   = `SRC_KIND_VOLT;
        hitNeg = 1'b1;
      end
      `SRC_SEL_V_BOTH: begin
        kind   = `SRC_KIND_VOLT;
        hitPos = 1'b1;
        hitNeg = 1'b1;
      end
      // resistor to ground, level read as a resistor value
      `SRC_SEL_R_POS: begin
        kind   = `SRC_KIND_RES;
        hitPos = 1'b1;
      end
      `SRC_SEL_R_NEG: begin
        kind   = `SRC_KIND_RES;
        hitNeg = 1'b1;
      end
      `SRC_SEL_R_BOTH: begin
        kind   = `SRC_KIND_RES;
        hitPos = 1'b1;
        hitNeg = 1'b1;
      end
      // supply divider, level read as minimum total resistance
      `SRC_SEL_DIV_POS: begin
        kind   = `SRC_KIND_DIV;
        hitPos = 1'b1;
      end
      `SRC_SEL_DIV_NEG: begin
        kind   = `SRC_KIND_DIV;
        hitNeg = 1'b1;
      end
      `SRC_SEL_DIV_BOTH: begin
        kind   = `SRC_KIND_DIV;
        hitPos = 1'b1;
        hitNeg = 1'b1;
      end
      // both pull-down codes behave alike
      `SRC_SEL_PD_A: begin
        pdCmd = 1'b1;
      end
      `SRC_SEL_PD_B: begin
        pdCmd = 1'b1;
      end
      default: begin
        kind = `SRC_KIND_NONE;
      end
    endcase
  end

  // only charging-port profiles act on a detected stimulus
  wire apply = stimDetected && chargePortProfile;
  wire clearAll = (selectQ == `SRC_SEL_REMOVE);
  wire isShort = (selectQ == `SRC_SEL_SHORT);
  wire trigBefore = (triggerSelectA == `SRC_TRIG_BEFORE);
  wire pdKeep = pdCmd && trigBefore;
  wire pdRemove = pdCmd && (triggerSelectA == `SRC_TRIG_AFTER);
  wire [1:0] posKindQ;
  wire [1:0] negKindQ;

  src_line_state uPos (
    .clk       (clk),
    .reset     (reset),
    .emuReset  (emuReset),
    .apply     (apply),
    .touch     (hitPos),
    .kind      (kind),
    .trigBefore(trigBefore),
    .pdKeep    (pdKeep),
    .pdRemove  (pdRemove),
    .clearAll  (clearAll),
    .kindQ     (posKindQ),
    .pullDownQ (portDataPositivePullDown)
  );

  src_line_state uNeg (
    .clk       (clk),
    .reset     (reset),
    .emuReset  (emuReset),
    .apply     (apply),
    .touch     (hitNeg),
    .kind      (kind),
    .trigBefore(trigBefore),
    .pdKeep    (pdKeep),
    .pdRemove  (pdRemove),
    .clearAll  (clearAll),
    .kindQ     (negKindQ),
    .pullDownQ (portDataNegativePullDown)
  );

  // applied level and short flag, level zeroed on remove and short, kept as it was on pull-down codes
  always @(posedge clk) begin
    if (reset || emuReset) begin
      appliedLevel <= 4'h0;
      linesShorted <= 1'b0;
    end else if (apply) begin
      if (clearAll) begin
        appliedLevel <= 4'h0;
        linesShorted <= 1'b0;
      end else if (isShort) begin
        appliedLevel <= 4'h0;
        linesShorted <= 1'b1;
      end else if (hitPos || hitNeg) begin
        appliedLevel <= levelQ;
      end
    end
  end

  // kinds registered once more so outputs come from flops
  always @(posedge clk) begin
    if (reset) begin
      portDataPositiveKind <= 2'h0;
      portDataNegativeKind <= 2'h0;
    end else begin
      portDataPositiveKind <= posKindQ;
      portDataNegativeKind <= negKindQ;
    end
  end

  // read data one cycle after the strobe, unmapped reads zero
  always @(posedge clk) begin
    if (reset)
      regRdata <= 8'h00;
    else if (regRead && regAddr == `SRC_ADDR_SETUP)
      regRdata <= {levelQ, selectQ};
    else if (regRead && regAddr == `SRC_ADDR_STATUS)
      regRdata <= {1'b0, linesShorted, portDataNegativePullDown, portDataPositivePullDown,
                   negKindQ, posKindQ};
    else
      regRdata <= 8'h00;
  end
endmodule // src_response_setup

// ==== shared/src_consts.vh ====
// Functional notes
// - Bits 7 to 4 of the response setup register hold the 4-bit response level, read per response type.
// - Bits 3 to 0 hold the 4-bit response select that picks the electrical response.
// - A write carrying a reserved code in a field leaves that field at its old value.
// - Selects 0001 to 0011 read the level as a voltage: 0000 pull-down, others 400 mV to 2200 mV.
// - Selects 0100, 0111 and 1101 read the level as a resistor, 1.8 kohm to 150 kohm.
// - Selects 0110, 1001, 1100 read the level as divider total resistance, 93 to 200 kohm.
// - Select 0000 removes any earlier response from both data lines.
// - Select 0001 drives voltage on the positive line, 0010 the negative, 0011 both.
// - Select 0100 puts the resistor on the positive line, 0111 the negative, 1101 both.
// - Select 0110 centres a divider on the positive line, 1001 the negative, 1100 both.
// - Select 1110/1111: trigger 000 keeps reset pull-downs, 111 removes them, else no change.
// - A single-line response with trigger 000 and no earlier response there keeps the pull-down.
// - The settings apply only in the charging-port profiles; other profiles ignore them.
`ifndef SRC_CONSTS_VH
`define SRC_CONSTS_VH
`define SRC_ADDR_SETUP     8'h3A
`define SRC_ADDR_STATUS    8'h3C
`define SRC_RESET_SETUP    8'h00
`define SRC_LEVEL_MSB      7
`define SRC_LEVEL_LSB      4
`define SRC_SEL_MSB        3
`define SRC_SEL_LSB        0
`define SRC_LEVEL_BAD      4'hF
`define SRC_SEL_BAD_A      4'h5
`define SRC_SEL_BAD_B      4'h8
`define SRC_SEL_BAD_C      4'hB
`define SRC_SEL_REMOVE     4'h0
`define SRC_SEL_V_POS      4'h1
`define SRC_SEL_V_NEG      4'h2
`define SRC_SEL_V_BOTH     4'h3
`define SRC_SEL_R_POS      4'h4
`define SRC_SEL_DIV_POS    4'h6
`define SRC_SEL_R_NEG      4'h7
`define SRC_SEL_DIV_NEG    4'h9
`define SRC_SEL_SHORT      4'hA
`define SRC_SEL_DIV_BOTH   4'hC
`define SRC_SEL_R_BOTH     4'hD
`define SRC_SEL_PD_A       4'hE
`define SRC_SEL_PD_B       4'hF
`define SRC_TRIG_BEFORE    3'h0
`define SRC_TRIG_AFTER     3'h7
`define SRC_KIND_NONE      2'h0
`define SRC_KIND_VOLT      2'h1
`define SRC_KIND_RES       2'h2
`define SRC_KIND_DIV       2'h3
`endif

// ==== core/src_line_state.v ====
`timescale 1ns/1ns
// one data line: pull-down and applied-response tracking
module src_line_state (
  // clock and reset
  input  wire       clk,
  input  wire       reset,
  // control
  input  wire       emuReset,
  input  wire       apply,
  input  wire       touch,
  input  wire [1:0] kind,
  input  wire       trigBefore,
  input  wire       pdKeep,
  input  wire       pdRemove,
  input  wire       clearAll,
  // state
  output reg  [1:0] kindQ,
  output reg        pullDownQ
);
  reg usedQ;

  // emulation reset restores the pull-down and forgets earlier responses
  always @(posedge clk) begin
    if (reset || emuReset) begin
      kindQ     <= 2'h0;
      pullDownQ <= 1'b1;
      usedQ     <= 1'b0;
    end else if (apply) begin
      if (clearAll) begin
        kindQ     <= 2'h0;
        pullDownQ <= 1'b0;
        usedQ     <= 1'b0;
      end else if (pdKeep) begin
        pullDownQ <= 1'b1;
      end else if (pdRemove) begin
        pullDownQ <= 1'b0;
      end else if (touch) begin
        kindQ     <= kind;
        usedQ     <= 1'b1;
        // pull-down survives only a first response before power-on
        pullDownQ <= pullDownQ && trigBefore && !usedQ;
      end
    end
  end
endmodule // src_line_state

// ==== sim/src_response_setup_props.sv ====
`timescale 1ns/1ns
// port-side checks for the response setup block
module src_response_setup_props (
  // clock, reset and register port
  input wire       clk, reset, regWrite, regRead,
  input wire [7:0] regAddr, regWdata, regRdata,
  // sequencer side
  input wire [2:0] triggerSelectA,
  input wire       stimDetected, chargePortProfile, emuReset,
  // response state
  input wire [1:0] portDataPositiveKind, portDataNegativeKind,
  input wire       portDataPositivePullDown, portDataNegativePullDown, linesShorted,
  input wire [3:0] appliedLevel
);
  reg  [7:0] sh_q;
  wire       ap  = stimDetected && chargePortProfile && !emuReset;
  wire [3:0] s   = sh_q[3:0];
  wire [3:0] lv  = sh_q[7:4];
  wire [1:0] pK  = portDataPositiveKind;
  wire [1:0] nK  = portDataNegativeKind;
  wire       pPd = portDataPositivePullDown;
  wire       nPd = portDataNegativePullDown;
  wire       okS = !(regWdata[3:0] inside {4'h5, 4'h8, 4'hB});
  // own copy of the setup byte, so reads are judged without the design's state
  always @(posedge clk)
    if (reset) sh_q <= 8'h00;
    else if (regWrite && regAddr == 8'h3A) begin
      if (regWdata[7:4] != 4'hF) sh_q[7:4] <= regWdata[7:4];
      if (okS) sh_q[3:0] <= regWdata[3:0];
    end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // an accepted stimulus while a given select is stored
  sequence s_app(logic [3:0] c); ap && s == c; endsequence
  // emulation reset, then one cycle with nothing applied, as the bench spaces them
  sequence s_fresh; emuReset ##1 !ap; endsequence
  property p_rd; regRead && regAddr == 8'h3A |=> regRdata == $past(sh_q); endproperty
  a_rd: assert property (p_rd) else $error("setup readback wrong");
  property p_vpos; s_app(4'h1) |=> ##1 pK == 2'h1; endproperty
  a_vpos: assert property (p_vpos) else $error("positive voltage kind");
  property p_rboth; s_app(4'hD) |=> ##1 pK == 2'h2 && nK == 2'h2; endproperty
  a_rboth: assert property (p_rboth) else $error("resistor both kind");
  property p_dboth; s_app(4'hC) |=> ##1 pK == 2'h3 && nK == 2'h3; endproperty
  a_dboth: assert property (p_dboth) else $error("divider both kind");
  property p_rem;
    s_app(4'h0) |=> !pPd && !nPd && appliedLevel == 4'h0 ##1 pK == 2'h0 && nK == 2'h0;
  endproperty
  a_rem: assert property (p_rem) else $error("remove left state");
  property p_short; s_app(4'hA) |=> linesShorted && appliedLevel == 4'h0; endproperty
  a_short: assert property (p_short) else $error("short state");
  property p_lvl;
    ap && (s == 4'h1 || s == 4'h4 || s == 4'h6) |=> appliedLevel == $past(lv);
  endproperty
  a_lvl: assert property (p_lvl) else $error("applied level");
  property p_pdoff; ap && s[3:1] == 3'h7 && triggerSelectA == 3'h7 |=> !pPd && !nPd; endproperty
  a_pdoff: assert property (p_pdoff) else $error("pull-downs kept");
  property p_prof;
    stimDetected && !chargePortProfile && !emuReset |=> $stable(appliedLevel) && $stable(pPd);
  endproperty
  a_prof: assert property (p_prof) else $error("applied outside profile");
  property p_first;
    s_fresh ##1 (ap && s == 4'h1 && triggerSelectA == 3'h0) |=> pPd && nPd;
  endproperty
  a_first: assert property (p_first) else $error("first pull-down lost");
endmodule // src_response_setup_props
bind src_response_setup src_response_setup_props src_response_setup_props_i (
  .clk(clk), .reset(reset), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata), .triggerSelectA(triggerSelectA),
  .stimDetected(stimDetected), .chargePortProfile(chargePortProfile), .emuReset(emuReset),
  .portDataPositiveKind(portDataPositiveKind), .portDataNegativeKind(portDataNegativeKind),
  .portDataPositivePullDown(portDataPositivePullDown),
  .portDataNegativePullDown(portDataNegativePullDown), .linesShorted(linesShorted),
  .appliedLevel(appliedLevel));

// ==== sim/src_response_setup_bench.sv ====
`timescale 1ns/1ns
// self-checking bench: register model plus a per-select line model
module src_response_setup_bench;
  reg         clk = 0, reset = 1, regWrite = 0, regRead = 0, stimDetected = 0;
  reg         chargePortProfile = 1, emuReset = 0;
  reg  [7:0]  regAddr = 8'h00, regWdata = 8'h00, m = 8'h00;
  reg  [2:0]  triggerSelectA = 3'h0;
  reg  [31:0] r = 32'h4D5F;
  reg  [3:0]  s, lv;
  reg  [1:0]  pk, nk;
  reg         pdP, pdN;
  wire [7:0]  rdq;
  wire [1:0]  pK, nK;
  wire        pPd, nPd, sht;
  wire [3:0]  lvl;
  integer     failures = 0, checks = 0, i, t;
  always #5 clk = ~clk;
  src_response_setup src_response_setup_i (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(rdq),
    .triggerSelectA(triggerSelectA), .stimDetected(stimDetected),
    .chargePortProfile(chargePortProfile), .emuReset(emuReset), .portDataPositiveKind(pK),
    .portDataPositivePullDown(pPd), .portDataNegativeKind(nK),
    .portDataNegativePullDown(nPd), .appliedLevel(lvl), .linesShorted(sht));
  function [31:0] lfsr(input [31:0] v); lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]}; endfunction
  task chk(input [7:0] a, input [7:0] x);
    begin
      checks = checks + 1;
      if (a !== x) begin
        failures = failures + 1;
        $display("mismatch at %0t got %h expected %h", $time, a, x);
      end
    end
  endtask
  // one-cycle strobes; a gap cycle keeps a strobe from being set twice in one step
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk) {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
      @(posedge clk) regWrite <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] x);
    begin
      @(posedge clk) {regAddr, regRead} <= {a, 1'b1};
      @(posedge clk) regRead <= 1'b0;
      @(negedge clk) chk(rdq, x);
    end
  endtask
  task kick(input e, input st, input p);
    begin
      @(posedge clk) {emuReset, stimDetected, chargePortProfile} <= {e, st, p};
      @(posedge clk) {emuReset, stimDetected} <= 2'b00;
    end
  endtask
  task test_done;
    begin
      if (failures == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // cut a hang short well past the expected run of about seven hundred cycles
  initial begin
    #100000 failures = failures + 1;
    test_done;
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(8'h3A, 8'h00);
    wr(8'h3B, 8'hFF);
    rd(8'h3A, 8'h00);
    for (i = 0; i < 48; i = i + 1) begin
      r = lfsr(r);
      wr(8'h3A, r[7:0]);
      if (r[7:4] != 4'hF) m[7:4] = r[7:4];
      if (!(r[3:0] inside {4'h5, 4'h8, 4'hB})) m[3:0] = r[3:0];
      rd(8'h3A, m);
    end
    // every select under trigger 000, 111 and one other value, from a fresh line state
    for (t = 0; t < 3; t = t + 1) for (i = 0; i < 13; i = i + 1) begin
      s = 52'h1234679CDAEF0 >> (48 - 4 * i);
      r = lfsr(r);
      lv = r[3:0] & 4'hE;
      @(posedge clk) triggerSelectA <= (t == 0) ? 3'h0 : (t == 1) ? 3'h7 : 3'h3;
      wr(8'h3A, {lv, s});
      kick(1'b1, 1'b0, 1'b1);
      kick(1'b0, 1'b1, 1'b1);
      kick(1'b0, 1'b1, 1'b0);
      repeat (2) @(posedge clk);
      pk = (s == 1 || s == 3) ? 2'h1 : (s == 4 || s == 13) ? 2'h2
         : (s == 6 || s == 12) ? 2'h3 : 2'h0;
      nk = (s == 2 || s == 3) ? 2'h1 : (s == 7 || s == 13) ? 2'h2
         : (s == 9 || s == 12) ? 2'h3 : 2'h0;
      pdP = (pk != 0) ? (t == 0) : (s == 0) ? 1'b0 : (s >= 14) ? (t != 1) : 1'b1;
      pdN = (nk != 0) ? (t == 0) : (s == 0) ? 1'b0 : (s >= 14) ? (t != 1) : 1'b1;
      // status carries the short flag too, so the short select is read like the rest
      rd(8'h3C, {1'b0, s == 4'hA, pdN, pdP, nk, pk});
      // pull-down codes leave the level cleared by the emulation reset
      chk({4'h0, lvl},
          (s == 0 || s == 10 || s >= 14) ? 8'h00 : {4'h0, lv});
      chk({4'h0, pK, nK}, {4'h0, pk, nk});
      chk({7'h00, sht}, {7'h00, s == 4'hA});
    end
    test_done;
  end
endmodule // src_response_setup_bench
